/* File: bench/ddr2_mode_register_programming_test.sv */
// self-checking bench for the mode register block
`timescale 1ns/10ps
module ddr2_mode_register_programming_test;
   typedef struct packed {
      logic [2:0]  ba;
      logic [13:0] addr;
      logic [3:0]  flags;
   } dmr_row_t;
   // flags: burst 8, burst ok, latency ok, test mode of the current base register
   localparam dmr_row_t ROWS [6] = '{
      '{3'h0, 14'h0143, 4'b1110}, '{3'h0, 14'h0632, 4'b0110},
      '{3'h0, 14'h00a1, 4'b0001}, '{3'h1, 14'h0444, 4'b0001},
      '{3'h6, 14'h00a5, 4'b0001}, '{3'h3, 14'h0000, 4'b0001}};
   localparam logic [7:0] MASKS [8] = '{8'hff, 8'h0f, 8'h03, 8'h01,
                                        8'hfc, 8'hf0, 8'hc0, 8'h80};
   // extended 2 value standing for the hot-case doubled self refresh rate
   localparam logic [13:0] HOT_EMR2 = 14'h0080;
   logic clk_sys, rst, req, term_pin, bl8, bl_ok, cl_ok, test_mode;
   logic dll_reset, dll_on, dll_locked, self_refresh, busy;
   logic [1:0]  kind;
   logic [2:0]  ba, sw_exp;
   logic [13:0] addr;
   logic [12:0] emr2, emr3;
   logic [3:0]  load_pulse;
   logic [7:0]  bank_mask;
   logic [6:0]  t_exp;
   dmr_pkg::dmr_cmd_t  cmd;
   dmr_pkg::dmr_mr_t   mr;
   dmr_pkg::dmr_emr1_t emr1;
   dmr_pkg::dmr_term_t term;
   int err_total, compares, n;

   dmr_ctrl_model i_dmr_ctrl_model (.clk_sys_i(clk_sys), .rst_i(rst), .req_i(req),
      .kind_i(kind), .ba_i(ba), .addr_i(addr), .cmd_o(cmd), .busy_o(busy));
   dmr_mode_regs i_dmr_mode_regs (.clk_sys_i(clk_sys), .rst_i(rst), .cmd_i(cmd),
      .termination_control_i(term_pin), .mr_o(mr), .emr1_o(emr1), .emr2_o(emr2),
      .emr3_o(emr3), .burst_len_8_o(bl8), .burst_len_ok_o(bl_ok),
      .cas_latency_ok_o(cl_ok), .test_mode_o(test_mode), .load_pulse_o(load_pulse),
      .dll_reset_o(dll_reset), .dll_on_o(dll_on), .dll_locked_o(dll_locked),
      .self_refresh_o(self_refresh), .refresh_bank_mask_o(bank_mask), .term_o(term));

   always #12.5 clk_sys = ~clk_sys;

   task end_sim;
      $display("counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   task chk(input string name, input logic [12:0] exp, input logic [12:0] got);
      compares++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask : chk

   // returns just after the edge where the design shows the answer
   task issue(input logic [1:0] k, input logic [2:0] b, input logic [13:0] a);
      @(posedge clk_sys);
      req  <= 1'b1;
      kind <= k;
      ba   <= b;
      addr <= a;
      @(posedge clk_sys);
      req <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : issue

   task wait_idle;
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 50) begin
         err_total++;
         end_sim;
      end
   endtask : wait_idle

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      req = 1'b0;
      kind = 2'h0;
      ba = 3'h0;
      addr = 14'h0000;
      term_pin = 1'b0;
      err_total = 0;
      compares = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("mask", 13'h00ff, {5'h0, bank_mask});
      chk("locked", 13'h0, {12'h0, dll_locked});
      chk("term", 13'h0, {6'h0, term});
      $display("test reset done");
      // registers written in full before use, extended 3 with zeros
      foreach (ROWS[i]) begin
         issue(2'h0, ROWS[i].ba, ROWS[i].addr);
         chk("pulse", 13'(4'h1 << ROWS[i].ba[1:0]), {9'h0, load_pulse});
         case (ROWS[i].ba[1:0])
            2'h0: chk("mr", {1'b0, ROWS[i].addr[11:0]}, {1'b0, mr});
            2'h1: chk("emr1", {1'b0, ROWS[i].addr[11:0]}, {1'b0, emr1});
            2'h2: chk("emr2", ROWS[i].addr[12:0], emr2);
            default: chk("emr3", ROWS[i].addr[12:0], emr3);
         endcase
         chk("flags", {9'h0, ROWS[i].flags}, {9'h0, bl8, bl_ok, cl_ok, test_mode});
         wait_idle;
      end
      $display("test table done");
      issue(2'h0, 3'h0, 14'h0143);
      chk("dll_reset", 13'h1, {12'h0, dll_reset});
      repeat (190) @(posedge clk_sys);
      #1;
      chk("locked", 13'h0, {12'h0, dll_locked});
      n = 0;
      while (dll_locked !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("locked", 13'h1, {12'h0, dll_locked});
      if (n >= 20) begin
         end_sim;
      end
      $display("test dll lock done");
      @(posedge clk_sys);
      term_pin <= 1'b1;
      for (int r = 0; r < 8; r++) begin
         issue(2'h0, 3'h1, 14'({r[2], 3'h0, r[1], 3'h0, r[0], 2'h0}));
         wait_idle;
         repeat (2) @(posedge clk_sys);
         #1;
         sw_exp = (r[1:0] == 2'h1) ? 3'h1 : (r[1:0] == 2'h2) ? 3'h2 : 3'h4;
         t_exp = (r[1:0] == 2'h0) ? 7'h00 : {sw_exp, 3'b111, ~r[2]};
         chk("term", {6'h0, t_exp}, {6'h0, term});
      end
      issue(2'h0, 3'h1, 14'h0004);
      wait_idle;
      issue(2'h0, 3'h2, HOT_EMR2);
      chk("emr2", HOT_EMR2[12:0], emr2);
      wait_idle;
      issue(2'h1, 3'h0, 14'h0000);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("sr_on", 13'h2, {11'h0, self_refresh, dll_on});
      chk("term", 13'h0, {6'h0, term});
      issue(2'h2, 3'h0, 14'h0000);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("sr_on", 13'h1, {11'h0, self_refresh, dll_on});
      chk("term", 13'h001f, {6'h0, term});
      @(posedge clk_sys);
      term_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("term", 13'h0, {6'h0, term});
      $display("test termination done");
      for (int p = 0; p < 8; p++) begin
         issue(2'h0, 3'h2, 14'(p));
         repeat (2) @(posedge clk_sys);
         #1;
         chk("mask", {5'h0, MASKS[p]}, {5'h0, bank_mask});
         wait_idle;
      end
      $display("test partial refresh done");
      end_sim;
   end
endmodule : ddr2_mode_register_programming_test

/* File: bench/dmr_ctrl_model.sv */
// controller model issuing register loads and self refresh entry and exit
`timescale 1ns/10ps
module dmr_ctrl_model #(
   parameter int unsigned LOAD_CYCLE_TIME = 2
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        req_i,
   input  wire logic [1:0]  kind_i,
   input  wire logic [2:0]  ba_i,
   input  wire logic [13:0] addr_i,
   output dmr_pkg::dmr_cmd_t cmd_o,
   output logic             busy_o
);
   logic [3:0] gap_q;
   logic       sr_q;
   assign busy_o = (gap_q != 4'h0);
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cmd_o <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0000};
         gap_q <= 4'h0;
         sr_q  <= 1'b0;
      end else begin
         // deselected lines keep toggling so a stale value never looks valid
         cmd_o <= '{~sr_q, 1'b1, 1'b1, 1'b1, 1'b1, ~cmd_o.ba, ~cmd_o.addr};
         if (gap_q != 4'h0) begin
            gap_q <= gap_q - 4'h1;
         end
         if (req_i && !busy_o) begin
            case (kind_i)
               2'h0: begin
                  cmd_o <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ba_i, addr_i};
                  gap_q <= LOAD_CYCLE_TIME[3:0];
               end
               2'h1: begin
                  cmd_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ~cmd_o.ba, ~cmd_o.addr};
                  sr_q  <= 1'b1;
               end
               default: begin
                  cmd_o.cke <= 1'b1;
                  sr_q      <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : dmr_ctrl_model

/* File: hw/dmr_mode_regs.sv */
// ddr2 mode and extended mode register decode, field hold, dll and termination control
`timescale 1ns/10ps
// What this block does
// - both bank bits low on a load command writes the base mode register
// - bank bit 0 high, bit 1 low on a load writes extended register 1
// - bank bits 10 select extended register 2, bits 11 register 3
// - every load replaces every field of the addressed register
// - loads and dll reset never touch memory array contents
// - address bits 0..2 give burst length, only 4 and 8 supported
// - bit 3 burst order, bits 4..6 cas latency, no half-clock latencies
// - bit 7 test mode, low for normal; bit 8 high resets the dll
// - bits 9..11 hold write recovery in clocks, rounded up by controller
// - extended register 1 bit 0 high disables the dll, bit 1 reduced drive strength
// - bits 3..5 added latency, 2 and 6 termination, 7..9 calibration, 10, 11 strobes
// - dll turns off entering self refresh and back on leaving it
// - partial refresh field picks banks refreshed during self refresh
// - termination only in active or standby, off from the second cycle of self refresh on
// - termination pin closes one of three switches picked by termination value
// - no termination unless termination value bits are nonzero
// - data, mask, true strobe always terminated; complement strobe only if bit 10 low
module dmr_mode_regs (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   input  wire dmr_pkg::dmr_cmd_t cmd_i,
   input  wire logic              termination_control_i,
   output dmr_pkg::dmr_mr_t       mr_o,
   output dmr_pkg::dmr_emr1_t     emr1_o,
   output logic [12:0]            emr2_o,
   output logic [12:0]            emr3_o,
   output logic                   burst_len_8_o,
   output logic                   burst_len_ok_o,
   output logic                   cas_latency_ok_o,
   output logic                   test_mode_o,
   output logic [3:0]             load_pulse_o,
   output logic                   dll_reset_o,
   output logic                   dll_on_o,
   output logic                   dll_locked_o,
   output logic                   self_refresh_o,
   output logic [7:0]             refresh_bank_mask_o,
   output dmr_pkg::dmr_term_t     term_o
);

   typedef struct packed {
      dmr_pkg::dmr_mr_t   mr;
      dmr_pkg::dmr_emr1_t emr1;
      logic [12:0]        emr2;
      logic [12:0]        emr3;
      logic [3:0]         load;
      logic               dll_rst;
      logic [7:0]         lock_cnt;
      logic               locked;
      dmr_pkg::dmr_pwr_t  pwr;
      logic               cke;
      dmr_pkg::dmr_term_t term;
      logic [7:0]         bank_mask;
   } dmr_state_t;

   dmr_state_t st_q;
   dmr_state_t st_d;

   logic       cmd_load;
   logic       sr_enter;
   logic       sr_exit;
   logic [1:0] rtt;
   logic [2:0] partial_array_refresh;

   // a load needs all four strobes low; the controller guarantees bank state and cke
   assign cmd_load = ~cmd_i.cs_n & ~cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
   // self refresh entry is the refresh command registered with cke falling
   assign sr_enter = st_q.cke & ~cmd_i.cke & ~cmd_i.cs_n & ~cmd_i.ras_n & ~cmd_i.cas_n
                     & cmd_i.we_n;
   assign sr_exit  = (st_q.pwr == dmr_pkg::DMR_ST_SELF_REF) & cmd_i.cke;
   assign rtt      = {st_q.emr1.rtt_hi, st_q.emr1.rtt_lo};
   assign partial_array_refresh     = st_q.emr2[dmr_pkg::DMR_PARTIAL_ARRAY_REFRESH_LSB +: 3];

   always_comb begin
      st_d         = st_q;
      st_d.load    = 4'h0;
      st_d.dll_rst = 1'b0;
      st_d.cke     = cmd_i.cke;

      // whole-register writes; nothing here reaches the array
      if (cmd_load) begin
         unique case (cmd_i.ba[1:0])
            dmr_pkg::DMR_BA_MR: begin
               st_d.mr      = dmr_pkg::dmr_mr_t'(cmd_i.addr[11:0]);
               st_d.load[0] = 1'b1;
               st_d.dll_rst = cmd_i.addr[8];
            end
            dmr_pkg::DMR_BA_EMR1: begin
               st_d.emr1    = dmr_pkg::dmr_emr1_t'(cmd_i.addr[11:0]);
               st_d.load[1] = 1'b1;
            end
            dmr_pkg::DMR_BA_EMR2: begin
               st_d.emr2    = cmd_i.addr[12:0];
               st_d.load[2] = 1'b1;
            end
            dmr_pkg::DMR_BA_EMR3: begin
               st_d.emr3    = cmd_i.addr[12:0];
               st_d.load[3] = 1'b1;
            end
         endcase
      end

      unique case (st_q.pwr)
         dmr_pkg::DMR_ST_NORMAL: begin
            if (sr_enter) begin
               st_d.pwr = dmr_pkg::DMR_ST_SELF_REF;
            end
         end
         dmr_pkg::DMR_ST_SELF_REF: begin
            if (sr_exit) begin
               st_d.pwr = dmr_pkg::DMR_ST_NORMAL;
            end
         end
         default: begin
            st_d.pwr = dmr_pkg::DMR_ST_NORMAL;
         end
      endcase

      // lock restarts on any dll reset or self refresh exit, informational only
      if (st_q.dll_rst || sr_exit || st_q.emr1.dll_dis) begin
         st_d.lock_cnt = 8'h00;
         st_d.locked   = 1'b0;
      end else if (st_q.pwr == dmr_pkg::DMR_ST_SELF_REF) begin
         st_d.locked   = 1'b0;
      end else if (!st_q.locked) begin
         st_d.lock_cnt = st_q.lock_cnt + 8'h01;
         st_d.locked   = (st_q.lock_cnt + 8'h01) == dmr_pkg::DMR_LOCK_CLKS;
      end

      // termination: pin, nonzero value, not self refresh
      st_d.term = '0;
      if (termination_control_i && (rtt != 2'h0)
          && (st_q.pwr == dmr_pkg::DMR_ST_NORMAL)) begin
         st_d.term.sw         = 3'h1 << (rtt - 2'h1);
         st_d.term.dq         = 1'b1;
         st_d.term.dm         = 1'b1;
         st_d.term.strobe     = 1'b1;
         st_d.term.strobe_cmp = ~st_q.emr1.strobe_cmp_dis;
      end

      // partial refresh: banks kept alive during self refresh
      unique case (partial_array_refresh)
         3'h0: st_d.bank_mask = 8'hff;
         3'h1: st_d.bank_mask = 8'h0f;
         3'h2: st_d.bank_mask = 8'h03;
         3'h3: st_d.bank_mask = 8'h01;
         3'h4: st_d.bank_mask = 8'hfc;
         3'h5: st_d.bank_mask = 8'hf0;
         3'h6: st_d.bank_mask = 8'hc0;
         3'h7: st_d.bank_mask = 8'h80;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_q.mr        <= dmr_pkg::DMR_MR_RST;
         st_q.emr1      <= dmr_pkg::DMR_EMR1_RST;
         st_q.emr2      <= dmr_pkg::DMR_EMRX_RST;
         st_q.emr3      <= dmr_pkg::DMR_EMRX_RST;
         st_q.load      <= 4'h0;
         st_q.dll_rst   <= 1'b0;
         st_q.lock_cnt  <= 8'h00;
         st_q.locked    <= 1'b0;
         st_q.pwr       <= dmr_pkg::DMR_ST_NORMAL;
         st_q.cke       <= 1'b0;
         st_q.term      <= '0;
         st_q.bank_mask <= 8'hff;
      end else begin
         st_q <= st_d;
      end
   end

   assign mr_o                = st_q.mr;
   assign emr1_o              = st_q.emr1;
   assign emr2_o              = st_q.emr2;
   assign emr3_o              = st_q.emr3;
   assign burst_len_8_o       = st_q.mr.bl == dmr_pkg::DMR_BL_8;
   assign burst_len_ok_o      = (st_q.mr.bl == dmr_pkg::DMR_BL_4)
                                | (st_q.mr.bl == dmr_pkg::DMR_BL_8);
   // only whole-clock latencies exist; other codes are flagged
   assign cas_latency_ok_o    = st_q.mr.cl >= dmr_pkg::DMR_CL_MIN;
   assign test_mode_o         = st_q.mr.test;
   assign load_pulse_o        = st_q.load;
   assign dll_reset_o         = st_q.dll_rst;
   assign dll_on_o            = ~st_q.emr1.dll_dis
                                & (st_q.pwr == dmr_pkg::DMR_ST_NORMAL);
   assign dll_locked_o        = st_q.locked;
   assign self_refresh_o      = st_q.pwr == dmr_pkg::DMR_ST_SELF_REF;
   assign refresh_bank_mask_o = st_q.bank_mask;
   assign term_o              = st_q.term;

   // checks
   AST_MR_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 |=> mr_o == $past(cmd_i.addr[11:0]) && load_pulse_o[0])
      else $error("base register load not taken");

   AST_EMR1_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h1 |=> emr1_o == $past(cmd_i.addr[11:0]) && mr_o == $past(mr_o))
      else $error("extended register 1 load wrong");

   AST_EMR23_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1] |=> (($past(cmd_i.ba[0]) ? emr3_o : emr2_o) == $past(cmd_i.addr[12:0])))
      else $error("extended register 2 or 3 load wrong");

   AST_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !cmd_load |=> $stable(mr_o) && $stable(emr1_o) && load_pulse_o == 4'h0)
      else $error("register changed without a load");

   AST_DLL_RST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 && cmd_i.addr[8] |=> dll_reset_o ##1 !dll_locked_o)
      else $error("dll reset not pulsed");

   AST_LOCK_TIME: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(dll_locked_o) |-> st_q.lock_cnt == dmr_pkg::DMR_LOCK_CLKS && !$past(dll_reset_o))
      else $error("dll lock time wrong");

   AST_SR_DLL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sr_enter |=> self_refresh_o && !dll_on_o ##1 !term_o.dq)
      else $error("dll or termination on in self refresh");

   AST_TERM_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!termination_control_i || rtt == 2'h0 || self_refresh_o) |=> term_o == '0)
      else $error("termination on when it must be off");

   AST_TERM_SW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      termination_control_i && rtt == 2'h3 && !self_refresh_o && !cmd_load
      |=> term_o.sw == 3'h4 && term_o.strobe_cmp == !emr1_o.strobe_cmp_dis)
      else $error("termination switch or strobe wrong");

   AST_PARTIAL_ARRAY_REFRESH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      partial_array_refresh == 3'h4 |=> refresh_bank_mask_o == 8'hfc)
      else $error("partial refresh mask wrong");

   // further checks: load fields and decodes, self refresh, dll lock, partial refresh masks and termination
   AST_PULSE_ONEHOT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $onehot0(load_pulse_o))
      else $error("more than one register loaded at once");

   AST_BL8_OK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      burst_len_8_o |-> burst_len_ok_o)
      else $error("burst 8 flagged as unsupported");

   AST_BL_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 && cmd_i.addr[2:0] == dmr_pkg::DMR_BL_4
      |=> burst_len_ok_o && !burst_len_8_o)
      else $error("burst 4 decode wrong");

   AST_BT_FIELD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 |=> mr_o.bt == $past(cmd_i.addr[3]))
      else $error("burst order field wrong");

   AST_CL_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 && cmd_i.addr[6:4] >= dmr_pkg::DMR_CL_MIN
      |=> cas_latency_ok_o)
      else $error("legal cas latency flagged");

   AST_CL_BAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 && cmd_i.addr[6:4] < dmr_pkg::DMR_CL_MIN
      |=> !cas_latency_ok_o)
      else $error("unsupported cas latency accepted");

   AST_TEST_MODE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 |=> test_mode_o == $past(cmd_i.addr[7]))
      else $error("test mode bit wrong");

   AST_DLL_RST_SRC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      dll_reset_o |-> $past(cmd_load && cmd_i.ba[1:0] == 2'h0 && cmd_i.addr[8]))
      else $error("dll reset without a base load");

   AST_WR_FIELD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 |=> mr_o.wr == $past(cmd_i.addr[11:9]))
      else $error("write recovery field wrong");

   AST_DLL_DIS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h1 && cmd_i.addr[0] |=> !dll_on_o)
      else $error("dll on while disabled");

   AST_DRIVE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h1 |=> emr1_o.reduced_drive == $past(cmd_i.addr[1]))
      else $error("drive strength field wrong");

   AST_AL_FIELD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h1 |=> emr1_o.added_latency == $past(cmd_i.addr[5:3]))
      else $error("added latency field wrong");

   AST_STROBE_FIELD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h1 |=> emr1_o.strobe_cmp_dis == $past(cmd_i.addr[10])
      && emr1_o.read_strobe_en == $past(cmd_i.addr[11]))
      else $error("strobe option fields wrong");

   AST_SR_EXIT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      self_refresh_o && cmd_i.cke |=> !self_refresh_o && !dll_locked_o)
      else $error("self refresh exit wrong");

   AST_SR_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      self_refresh_o && !cmd_i.cke |=> self_refresh_o)
      else $error("self refresh left early");

   AST_LOCK_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      dll_locked_o && !dll_reset_o && !self_refresh_o && !emr1_o.dll_dis |=> dll_locked_o)
      else $error("dll lock dropped without cause");

   AST_PARTIAL_ARRAY_REFRESH_FULL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      partial_array_refresh == 3'h0 |=> refresh_bank_mask_o == 8'hff)
      else $error("full array mask wrong");

   AST_PARTIAL_ARRAY_REFRESH_TOP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      partial_array_refresh == 3'h7 |=> refresh_bank_mask_o == 8'h80)
      else $error("top bank mask wrong");

   AST_TERM_SW1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      termination_control_i && rtt == 2'h1 && !self_refresh_o |=> term_o.sw == 3'h1)
      else $error("first termination switch not chosen");

   AST_TERM_PINS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      termination_control_i && rtt != 2'h0 && !self_refresh_o
      |=> term_o.dq && term_o.dm && term_o.strobe)
      else $error("data mask or strobe not terminated");

   AST_EMRX_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !cmd_load |=> $stable(emr2_o) && $stable(emr3_o))
      else $error("extended register changed without a load");

   COV_MR: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_load && cmd_i.ba[1:0] == 2'h0 && cmd_i.addr[8]);
   COV_LOCK: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(dll_locked_o));
   COV_SR: cover property (@(posedge clk_sys_i) disable iff (rst_i) sr_enter ##[1:50] sr_exit);
   COV_TERM: cover property (@(posedge clk_sys_i) disable iff (rst_i) term_o.strobe_cmp);
   COV_EMR3: cover property (@(posedge clk_sys_i) disable iff (rst_i) load_pulse_o[3]);

endmodule : dmr_mode_regs

/* File: pkg/dmr_pkg.sv */
// constants and carrier types for the ddr2 mode register programming block
package dmr_pkg;

   // command pin bundle sampled on each rising clock edge
   typedef struct packed {
      logic        cke;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [2:0]  ba;
      logic [13:0] addr;
   } dmr_cmd_t;

   // base mode register, bit order follows address bits 11..0
   typedef struct packed {
      logic [2:0] wr;
      logic       dll_rst;
      logic       test;
      logic [2:0] cl;
      logic       bt;
      logic [2:0] bl;
   } dmr_mr_t;

   // extended register 1, bit order follows address bits 11..0
   typedef struct packed {
      logic       read_strobe_en;
      logic       strobe_cmp_dis;
      logic [2:0] driver_calibration;
      logic       rtt_hi;
      logic [2:0] added_latency;
      logic       rtt_lo;
      logic       reduced_drive;
      logic       dll_dis;
   } dmr_emr1_t;

   // termination outputs
   typedef struct packed {
      logic [2:0] sw;
      logic       dq;
      logic       dm;
      logic       strobe;
      logic       strobe_cmp;
   } dmr_term_t;

   typedef enum logic [1:0] {
      DMR_ST_NORMAL   = 2'b01,
      DMR_ST_SELF_REF = 2'b10
   } dmr_pwr_t;

   localparam int unsigned DMR_REG_W      = 13;
   localparam logic [1:0]  DMR_BA_MR      = 2'h0;
   localparam logic [1:0]  DMR_BA_EMR1    = 2'h1;
   localparam logic [1:0]  DMR_BA_EMR2    = 2'h2;
   localparam logic [1:0]  DMR_BA_EMR3    = 2'h3;
   localparam logic [2:0]  DMR_BL_4       = 3'h2;
   localparam logic [2:0]  DMR_BL_8       = 3'h3;
   localparam logic [2:0]  DMR_CL_MIN     = 3'h3;
   localparam logic [2:0]  DMR_CL_MAX     = 3'h7;
   localparam int unsigned DMR_PARTIAL_ARRAY_REFRESH_LSB   = 0;
   localparam logic [7:0]  DMR_LOCK_CLKS  = 8'hc8;
   localparam logic [11:0] DMR_MR_RST     = 12'h000;
   localparam logic [11:0] DMR_EMR1_RST   = 12'h000;
   localparam logic [12:0] DMR_EMRX_RST   = 13'h0000;

endpackage : dmr_pkg
